// ### rtl/dcc_pkg.sv
package dcc_pkg;
  localparam logic [31:0] CTRL_OFFSET = 32'h5000356C;
  localparam logic [31:0] SRC_OFFSET = 32'h00000000;
  localparam logic [31:0] DST_OFFSET = 32'h00000004;
  localparam logic [31:0] LEN_OFFSET = 32'h00000008;
  localparam logic [31:0] INTC_OFFSET = 32'h0000000C;
  localparam logic [31:0] IDX_OFFSET = 32'h00000010;
  localparam logic [31:0] STAT_OFFSET = 32'h00000014;
  localparam logic [31:0] PEER_OFFSET = 32'h00000018;
  localparam logic [31:0] WDATA_OFFSET = 32'h0000001C;
  localparam logic [31:0] RDATA_OFFSET = 32'h00000020;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] CTRL_WMASK = 16'h07FF;
  localparam int RUN_BIT = 0;
  localparam int WIDTH_LO = 1;
  localparam int WIDTH_HI = 2;
  localparam int IRQ_EN_BIT = 3;
  localparam int TRIG_BIT = 4;
  localparam int DINC_BIT = 5;
  localparam int SINC_BIT = 6;
  localparam int WRAP_BIT = 7;
  localparam int PRIO_LO = 8;
  localparam int PRIO_HI = 10;
  localparam logic [1:0] WIDTH_BYTE = 2'h0;
  localparam logic [1:0] WIDTH_HALF = 2'h1;
  localparam logic [1:0] WIDTH_WORD = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int FIFO_WIDTH = 32;
  localparam int FIFO_DEPTH = 16;
  localparam int PEERS = 2;
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_MOVE} dcc_state_t;
endpackage : dcc_pkg

// ### rtl/dcc_stream_if.sv
`timescale 1ns/1ns
`default_nettype none
interface dcc_stream_if;
  logic [31:0] data;
  logic valid;
  logic ready;
  modport src(output data, output valid, input ready);
  modport snk(input data, input valid, output ready);
endinterface : dcc_stream_if
`default_nettype wire

// ### rtl/dcc_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module dcc_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic flush,
  dcc_stream_if.snk in_s,
  dcc_stream_if.src out_s
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wptr_reg;
  logic [AW-1:0] rptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;
  assign in_s.ready = (count_reg != DEPTH[AW:0]);
  assign out_s.valid = (count_reg != '0);
  assign out_s.data = mem_reg[rptr_reg];
  assign push = in_s.valid && in_s.ready;
  assign pop = out_s.valid && out_s.ready;
  always_ff @(posedge aclk) begin
    if (push) begin
      mem_reg[wptr_reg] <= in_s.data;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || flush) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wptr_reg <= wptr_reg + 1'b1;
      end
      if (pop) begin
        rptr_reg <= rptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule : dcc_fifo
`default_nettype wire

// ### rtl/dcc_arbiter.sv
`timescale 1ns/1ns
`default_nettype none
module dcc_arbiter #(
  parameter int N = 3
) (
  input wire logic [N-1:0] req,
  input wire logic [3*N-1:0] prio,
  output logic [N-1:0] grant
);
  // later stages only win on strictly greater rank, so equal rank keeps the lower index
  localparam int WB = $clog2(N+1);
  logic [2:0] best [N+1];
  logic [WB-1:0] win [N+1];
  logic found [N+1];
  assign best[0] = 3'h0;
  assign win[0] = '0;
  assign found[0] = 1'b0;
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_stage
      logic take;
      assign take = req[i] && (!found[i] || (prio[3*i +: 3] > best[i]));
      assign best[i+1] = take ? prio[3*i +: 3] : best[i];
      assign win[i+1] = take ? WB'(i) : win[i];
      assign found[i+1] = found[i] || req[i];
      assign grant[i] = found[N] && (win[N] == WB'(i));
    end
  endgenerate
endmodule : dcc_arbiter
`default_nettype wire

// ### rtl/dcc_channel.sv
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
module dcc_channel (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic periph_request,
  input wire logic [3*dcc_pkg::PEERS-1:0] peer_priority,
  input wire logic [dcc_pkg::PEERS-1:0] peer_request,
  output logic [dcc_pkg::PEERS-1:0] peer_grant,
  output logic bus_grant,
  output logic [31:0] item_src_addr,
  output logic [31:0] item_dst_addr,
  output logic [1:0] item_width,
  output logic item_strobe,
  output logic channel_irq,
  output logic [31:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  logic [15:0] ctrl_reg;
  logic [31:0] src_reg;
  logic [31:0] dst_reg;
  logic [15:0] len_reg;
  logic [15:0] intc_reg;
  logic [15:0] idx_reg;
  logic irq_reg;
  logic done_reg;
  logic [31:0] src_addr_reg;
  logic [31:0] dst_addr_reg;
  logic strobe_reg;
  logic [31:0] rdata_reg;
  logic rvalid_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic [1:0] rresp_reg;
  logic aw_held_reg;
  logic w_held_reg;
  logic [31:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  dcc_pkg::dcc_state_t state_reg;
  logic run;
  logic wrap;
  logic trig;
  logic [1:0] width;
  logic width_ok;
  logic [2:0] step;
  logic own_req;
  logic own_grant;
  logic item_go;
  logic last_item;
  logic wr_do;
  logic [31:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [31:0] wr_mask;
  logic ctrl_hit;
  logic feed_hit;
  logic [dcc_pkg::PEERS:0] all_req;
  logic [3*dcc_pkg::PEERS+2:0] all_prio;
  logic [dcc_pkg::PEERS:0] all_grant;
  dcc_stream_if in_s ();
  dcc_stream_if out_s ();

  assign run = ctrl_reg[dcc_pkg::RUN_BIT];
  assign wrap = ctrl_reg[dcc_pkg::WRAP_BIT] && trig;
  assign trig = ctrl_reg[dcc_pkg::TRIG_BIT];
  assign width = ctrl_reg[dcc_pkg::WIDTH_HI:dcc_pkg::WIDTH_LO];
  assign width_ok = (width != 2'h3);

  always_comb begin
    case (width)
      dcc_pkg::WIDTH_BYTE: step = 3'h1;
      dcc_pkg::WIDTH_HALF: step = 3'h2;
      dcc_pkg::WIDTH_WORD: step = 3'h4;
      default: step = 3'h0;
    endcase
  end

  // a reserved width stalls the channel rather than guessing a size
  assign own_req = run && width_ok && (state_reg == dcc_pkg::ST_MOVE)
                   && in_s.ready;
  assign all_req = {peer_request, own_req};
  assign all_prio = {peer_priority, ctrl_reg[dcc_pkg::PRIO_HI:dcc_pkg::PRIO_LO]};

  dcc_arbiter #(.N(dcc_pkg::PEERS + 1)) u_arb (
    .req(all_req),
    .prio(all_prio),
    .grant(all_grant)
  );

  assign own_grant = all_grant[0];
  assign peer_grant = all_grant[dcc_pkg::PEERS:1];
  assign bus_grant = own_grant;
  assign item_go = own_req && own_grant;
  assign last_item = (idx_reg == len_reg);

  // axi write channels: address and data may arrive in either order
  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready = !w_held_reg && !bvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign wr_addr = aw_held_reg ? aw_addr_reg : s_axi_awaddr;
  assign wr_data = w_held_reg ? w_data_reg : s_axi_wdata;
  assign wr_strb = w_held_reg ? w_strb_reg : s_axi_wstrb;
  assign wr_do = (aw_held_reg || (s_axi_awvalid && s_axi_awready))
                 && (w_held_reg || (s_axi_wvalid && s_axi_wready));
  assign wr_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
  assign ctrl_hit = wr_do && (wr_addr == dcc_pkg::CTRL_OFFSET);
  assign feed_hit = wr_do && (wr_addr == dcc_pkg::WDATA_OFFSET);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= 32'h00000000;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= dcc_pkg::RESP_OKAY;
    end else begin
      if (wr_do) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= (feed_hit && !in_s.ready) ? dcc_pkg::RESP_SLVERR : dcc_pkg::RESP_OKAY;
      end else begin
        if (s_axi_awvalid && s_axi_awready) begin
          aw_held_reg <= 1'b1;
          aw_addr_reg <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_held_reg <= 1'b1;
          w_data_reg <= s_axi_wdata;
          w_strb_reg <= s_axi_wstrb;
        end
        if (bvalid_reg && s_axi_bready) begin
          bvalid_reg <= 1'b0;
        end
      end
    end
  end

  // control register: software write first, hardware self-clear of run wins last
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= dcc_pkg::CTRL_RESET;
    end else begin
      if (ctrl_hit) begin
        ctrl_reg <= (ctrl_reg & ~(wr_mask[15:0] & dcc_pkg::CTRL_WMASK))
                    | (wr_data[15:0] & wr_mask[15:0] & dcc_pkg::CTRL_WMASK);
      end
      if (item_go && last_item && !wrap) begin
        ctrl_reg[dcc_pkg::RUN_BIT] <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_reg <= 32'h00000000;
      dst_reg <= 32'h00000000;
      len_reg <= 16'h0000;
      intc_reg <= 16'h0000;
    end else if (wr_do) begin
      if (wr_addr == dcc_pkg::SRC_OFFSET) begin
        src_reg <= (src_reg & ~wr_mask) | (wr_data & wr_mask);
      end
      if (wr_addr == dcc_pkg::DST_OFFSET) begin
        dst_reg <= (dst_reg & ~wr_mask) | (wr_data & wr_mask);
      end
      if (wr_addr == dcc_pkg::LEN_OFFSET) begin
        len_reg <= (len_reg & ~wr_mask[15:0]) | (wr_data[15:0] & wr_mask[15:0]);
      end
      if (wr_addr == dcc_pkg::INTC_OFFSET) begin
        intc_reg <= (intc_reg & ~wr_mask[15:0]) | (wr_data[15:0] & wr_mask[15:0]);
      end
    end
  end

  // sequencing: idle until run, wait for a peripheral request when triggered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= dcc_pkg::ST_IDLE;
    end else begin
      case (state_reg)
        dcc_pkg::ST_IDLE: begin
          if (run) begin
            state_reg <= trig ? dcc_pkg::ST_WAIT : dcc_pkg::ST_MOVE;
          end
        end
        dcc_pkg::ST_WAIT: begin
          if (!run) begin
            state_reg <= dcc_pkg::ST_IDLE;
          end else if (periph_request) begin
            state_reg <= dcc_pkg::ST_MOVE;
          end
        end
        dcc_pkg::ST_MOVE: begin
          if (!run) begin
            state_reg <= dcc_pkg::ST_IDLE;
          end else if (item_go && trig) begin
            state_reg <= (last_item && !wrap) ? dcc_pkg::ST_IDLE : dcc_pkg::ST_WAIT;
          end else if (item_go && last_item) begin
            state_reg <= dcc_pkg::ST_IDLE;
          end
        end
        default: state_reg <= dcc_pkg::ST_IDLE;
      endcase
    end
  end

  // index counts items; cleared on completion, on wrap and when stopped
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      idx_reg <= 16'h0000;
    end else if (item_go) begin
      idx_reg <= last_item ? 16'h0000 : idx_reg + 16'h0001;
    end
  end

  // each address is the start plus index times step when its own bit (SINC_BIT for source, DINC_BIT for destination) is set, else the start; computed per item
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_addr_reg <= 32'h00000000;
      dst_addr_reg <= 32'h00000000;
      strobe_reg <= 1'b0;
    end else begin
      strobe_reg <= item_go;
      if (item_go) begin
        src_addr_reg <= ctrl_reg[dcc_pkg::SINC_BIT]
                        ? src_reg + ({16'h0000, idx_reg} * {29'h0, step}) : src_reg;
        dst_addr_reg <= ctrl_reg[dcc_pkg::DINC_BIT]
                        ? dst_reg + ({16'h0000, idx_reg} * {29'h0, step}) : dst_reg;
      end
    end
  end

  assign item_src_addr = src_addr_reg;
  assign item_dst_addr = dst_addr_reg;
  assign item_width = width;
  assign item_strobe = strobe_reg;

  // sticky interrupt; a new match in the clearing cycle keeps it set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      if (wr_do && wr_addr == dcc_pkg::STAT_OFFSET && wr_strb[0] && wr_data[0]) begin
        irq_reg <= 1'b0;
      end
      if (wr_do && wr_addr == dcc_pkg::STAT_OFFSET && wr_strb[0] && wr_data[1]) begin
        done_reg <= 1'b0;
      end
      if (item_go && ctrl_reg[dcc_pkg::IRQ_EN_BIT] && intc_reg == idx_reg) begin
        irq_reg <= 1'b1;
      end
      if (item_go && last_item) begin
        done_reg <= 1'b1;
      end
    end
  end

  assign channel_irq = irq_reg && ctrl_reg[dcc_pkg::IRQ_EN_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= dcc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= dcc_pkg::RESP_OKAY;
      case (s_axi_araddr)
        dcc_pkg::CTRL_OFFSET: rdata_reg <= {16'h0000, ctrl_reg};
        dcc_pkg::SRC_OFFSET: rdata_reg <= src_reg;
        dcc_pkg::DST_OFFSET: rdata_reg <= dst_reg;
        dcc_pkg::LEN_OFFSET: rdata_reg <= {16'h0000, len_reg};
        dcc_pkg::INTC_OFFSET: rdata_reg <= {16'h0000, intc_reg};
        dcc_pkg::IDX_OFFSET: rdata_reg <= {16'h0000, idx_reg};
        dcc_pkg::STAT_OFFSET: rdata_reg <= {26'h0, state_reg, in_s.ready, width_ok,
                                            done_reg, irq_reg};
        default: begin
          rdata_reg <= 32'h00000000;
          rresp_reg <= dcc_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // software feeds words into the fifo; the far side drains it, a full fifo stalls items
  assign in_s.data = wr_data;
  assign in_s.valid = feed_hit;

  dcc_fifo #(.WIDTH(dcc_pkg::FIFO_WIDTH), .DEPTH(dcc_pkg::FIFO_DEPTH)) u_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .flush(1'b0),
    .in_s(in_s),
    .out_s(out_s)
  );

  assign out_data = out_s.data;
  assign out_valid = out_s.valid;
  assign out_s.ready = out_ready;
endmodule : dcc_channel
`default_nettype wire

// ### testbench/dcc_channel_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module dcc_channel_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [3*dcc_pkg::PEERS-1:0] peer_priority,
  input wire logic [dcc_pkg::PEERS-1:0] peer_request,
  input wire logic [dcc_pkg::PEERS-1:0] peer_grant,
  input wire logic bus_grant,
  input wire logic [1:0] item_width,
  input wire logic item_strobe,
  input wire logic channel_irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_GRANT_ONEHOT: assert property ($onehot0({peer_grant, bus_grant}))
    else $error("more than one grant");
  AST_PRIO_HIGHER: assert property (peer_grant[0] |-> !(peer_request[1] && peer_priority[5:3] > peer_priority[2:0]))
    else $error("lower priority peer granted");
  AST_TIE_LOWER: assert property (peer_grant[1] |-> !(peer_request[0] && peer_priority[2:0] >= peer_priority[5:3]))
    else $error("tie not given to lower index");
  AST_GRANT_NEEDS_REQ: assert property ((peer_grant & ~peer_request) == 2'h0)
    else $error("grant without request");
  AST_NO_IDLE_BUS: assert property (|peer_request |-> |{peer_grant, bus_grant})
    else $error("bus idle while peers request");
  AST_STROBE_AFTER_GRANT: assert property (item_strobe |-> $past(bus_grant))
    else $error("item without grant");
  AST_WIDTH_LEGAL: assert property (item_strobe |-> item_width != 2'h3)
    else $error("item moved with reserved width");
  AST_IRQ_AT_ITEM: assert property ($rose(channel_irq) |-> item_strobe)
    else $error("interrupt raised away from an item");
  AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_RDATA_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  cover property (item_strobe && channel_irq);
  cover property (peer_grant[1] && peer_request[0]);
  cover property (bus_grant ##1 item_strobe);
endmodule : dcc_channel_asserts
bind dcc_channel dcc_channel_asserts u_asserts (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .peer_priority, .peer_request, .peer_grant,
  .bus_grant, .item_width, .item_strobe, .channel_irq);
`default_nettype wire

// ### testbench/dcc_far_model.sv
`timescale 1ns/1ns
`default_nettype none
module dcc_far_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic fire,
  input wire logic stall,
  input wire logic bus_grant,
  output logic periph_request,
  output logic out_ready
);
  // a peripheral holds its request level until the item is granted
  always_ff @(posedge aclk) begin
    if (!aresetn || bus_grant) periph_request <= 1'h0;
    else if (fire) periph_request <= 1'h1;
  end
  assign out_ready = !stall;
endmodule : dcc_far_model
`default_nettype wire

// ### testbench/dcc_channel_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module dcc_channel_tb_top;
  logic aclk = 1'h0, aresetn = 1'h0, fire = 1'h0, stall = 1'h0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, item_width, peer_grant, peer_request = 2'h0;
  logic [5:0] peer_priority = 6'h0;
  logic [31:0] s_axi_rdata, item_src_addr, item_dst_addr, out_data;
  logic periph_request, bus_grant, item_strobe, channel_irq, out_valid, out_ready;
  logic [31:0] srcq[$], dstq[$], outq[$];
  int errors = 0, checks_done = 0, cyc = 0;
  dcc_channel uut (.*);
  dcc_far_model far (.*);
  always #20 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (item_strobe) begin
      srcq.push_back(item_src_addr);
      dstq.push_back(item_dst_addr);
    end
    if (out_valid && out_ready) outq.push_back(out_data);
    if (cyc == 30000) begin
      errors++;
      final_report();
    end
  end
  task automatic final_report;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ad, wd;
    ad = 1'h0;
    wd = 1'h0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      ad = ad | s_axi_awready;
      wd = wd | s_axi_wready;
    end while (!(ad && wd));
    s_axi_bready <= 1'h1;
    do @(posedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask : wr
  task automatic w(input logic [31:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
  endtask : w
  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    // one cycle late on purpose, so the slave must hold its answer
    @(posedge aclk);
    s_axi_rready <= 1'h1;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask : rd
  task automatic wait_done;
    logic [31:0] v;
    logic [1:0] r;
    for (int i = 0; i < 300; i++) begin
      rd(dcc_pkg::CTRL_OFFSET, v, r);
      if (v[0] === 1'h0) break;
    end
  endtask : wait_done
  task automatic pulse;
    fire <= 1'h1;
    @(posedge aclk);
    fire <= 1'h0;
    repeat (10) @(posedge aclk);
  endtask : pulse
  initial begin
    logic [31:0] v, c;
    logic [1:0] r;
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    rd(dcc_pkg::CTRL_OFFSET, v, r);
    chk(v, {16'h0, dcc_pkg::CTRL_RESET});
    rd(dcc_pkg::IDX_OFFSET, v, r);
    chk(v, 32'h0);
    rd(32'h00000040, v, r);
    chk(r, dcc_pkg::RESP_SLVERR);
    // reserved width with immediate start: running, yet nothing may move
    w(dcc_pkg::CTRL_OFFSET, 32'h0000FFEF);
    rd(dcc_pkg::CTRL_OFFSET, v, r);
    chk(v, {16'h0, dcc_pkg::CTRL_WMASK & 16'hFFEF});
    chk(srcq.size(), 32'h0);
    w(dcc_pkg::CTRL_OFFSET, 32'h0);
    $display("test registers done");
    for (int k = 0; k < 3; k++) begin
      srcq.delete();
      dstq.delete();
      w(dcc_pkg::SRC_OFFSET, 32'h00000100);
      w(dcc_pkg::DST_OFFSET, 32'h00000200);
      w(dcc_pkg::LEN_OFFSET, 32'h00000003);
      w(dcc_pkg::INTC_OFFSET, 32'h00000002);
      c = 32'h41 | (k << 1) | ((k != 1) << 3) | ((k != 0) << 5);
      w(dcc_pkg::CTRL_OFFSET, c);
      wait_done();
      chk(srcq.size(), 32'h4);
      chk(item_width, k);
      for (int i = 0; i < 4; i++) begin
        chk(srcq[i], 32'h100 + (i << k));
        chk(dstq[i], 32'h200 + ((k != 0) ? (i << k) : 0));
      end
      rd(dcc_pkg::CTRL_OFFSET, v, r);
      chk(v[0], 1'h0);
      rd(dcc_pkg::IDX_OFFSET, v, r);
      chk(v, 32'h0);
      chk(channel_irq, k != 1);
      w(dcc_pkg::STAT_OFFSET, 32'h00000003);
    end
    $display("test transfers done");
    srcq.delete();
    w(dcc_pkg::LEN_OFFSET, 32'h00000001);
    w(dcc_pkg::CTRL_OFFSET, 32'h00000040);
    repeat (20) @(posedge aclk);
    chk(srcq.size(), 32'h0);
    w(dcc_pkg::CTRL_OFFSET, 32'h00000051);
    repeat (20) @(posedge aclk);
    chk(srcq.size(), 32'h0);
    pulse();
    pulse();
    wait_done();
    chk(srcq.size(), 32'h2);
    srcq.delete();
    w(dcc_pkg::CTRL_OFFSET, 32'h000000D1);
    repeat (3) pulse();
    chk(srcq.size(), 32'h3);
    chk(srcq[2], 32'h100);
    rd(dcc_pkg::CTRL_OFFSET, v, r);
    chk(v[0], 1'h1);
    w(dcc_pkg::CTRL_OFFSET, 32'h0);
    $display("test triggering done");
    srcq.delete();
    peer_priority <= 6'h2B;
    peer_request <= 2'h3;
    w(dcc_pkg::LEN_OFFSET, 32'h00000003);
    w(dcc_pkg::CTRL_OFFSET, 32'h00000341);
    repeat (10) @(posedge aclk);
    chk(srcq.size(), 32'h0);
    chk(peer_grant, 2'h2);
    // equal priority with peer zero: this channel has the lower index
    peer_request <= 2'h1;
    wait_done();
    chk(srcq.size(), 32'h4);
    chk(peer_grant, 2'h1);
    peer_request <= 2'h0;
    $display("test arbitration done");
    stall <= 1'h1;
    outq.delete();
    for (int i = 0; i < 17; i++) begin
      wr(dcc_pkg::WDATA_OFFSET, i, r);
      chk(r, (i < 16) ? dcc_pkg::RESP_OKAY : dcc_pkg::RESP_SLVERR);
    end
    stall <= 1'h0;
    repeat (40) @(posedge aclk);
    chk(outq.size(), 32'h10);
    for (int i = 0; i < 16; i++) chk(outq[i], i);
    $display("test buffer done");
    final_report();
  end
endmodule : dcc_channel_tb_top
`default_nettype wire
